/* rfi_pkg.sv */
/*
 * Shared constants for the reader frontend interrupt controller:
 * register byte offsets, flag bit positions, reset values and the
 * bit-7 set/clear write function.
 * Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
 */
package rfi_pkg;

	localparam int          REG_W        = 8;
	localparam int          BUS_W        = 32;
	localparam int          ADDR_W       = 5;
	localparam int          N_TIMERS     = 4;

	// register byte offsets
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_FIRST   = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_SECOND  = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE_FIRST  = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE_SECOND = 5'h0C;
	localparam logic [ADDR_W-1:0] ADDR_STATUS_ONE    = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_PIN_CONFIG    = 5'h14;
	localparam logic [ADDR_W-1:0] ADDR_FIFO_THRESH   = 5'h18;

	// write-value layout
	localparam int              SETCLR_BIT  = 7;
	localparam logic [REG_W-1:0] FLAG_MASK  = 8'h7F;

	// first bank bit positions
	localparam int F1_RX_ERR   = 0;
	localparam int F1_FIFO_LO  = 1;
	localparam int F1_FIFO_HI  = 2;
	localparam int F1_CMD_DONE = 3;
	localparam int F1_RX_DONE  = 4;
	localparam int F1_TX_DONE  = 5;

	// second bank bit positions and source masks of both banks
	localparam int F2_TIMER0   = 0;
	localparam int F2_ANY      = 6;
	localparam logic [REG_W-1:0] F1_SRC_MASK = 8'h7F;
	localparam logic [REG_W-1:0] F2_SRC_MASK = 8'h3F;

	// status and configuration fields
	localparam int STAT_IRQ_BIT   = 0;
	localparam int CFG_PIN_EN_BIT = 0;

	// reset values
	localparam logic [REG_W-1:0] FLAGS_RST  = 8'h00;
	localparam logic [REG_W-1:0] ENABLE_RST = 8'h00;
	localparam logic             PIN_EN_RST = 1'h0;
	localparam logic [8:0]       THRESH_RST = 9'h008;

	// bit 7 of the written value picks set or clear of the marked bits 0..6
	function automatic logic [REG_W-1:0] rfi_setclr(input logic [REG_W-1:0] old,
		input logic [REG_W-1:0] wd);
		logic [REG_W-1:0] marked;
		marked = wd & FLAG_MASK;
		if (wd[SETCLR_BIT])
			return (old | marked) & FLAG_MASK;
		else
			return (old & ~marked) & FLAG_MASK;
	endfunction

endpackage

/* rfi_flag_bank.sv */
/*
 * One 8-bit interrupt controller register with bit-7 set/clear writes
 * and hardware set inputs; hardware set wins over a software clear.
 * Assumes wr_en is a single-cycle accepted-write strobe on clk_sys.
 */
`timescale 1ns/1ps
module rfi_flag_bank
	import rfi_pkg::*;
#(
	parameter logic [REG_W-1:0] RESET_VAL = FLAGS_RST
)
(
	input  wire logic             clk_sys,  // system clock
	input  wire logic             reset_n,  // synchronous reset, active low
	input  wire logic             wr_en,    // accepted write
	input  wire logic [REG_W-1:0] wr_data,  // written value, bit 7 selects set/clear
	input  wire logic [REG_W-1:0] hw_set,   // hardware set requests
	output logic      [REG_W-1:0] value     // current register contents
);

	typedef struct packed {
		logic [REG_W-1:0] bits;
	} rfi_bank_state_t;

	rfi_bank_state_t state_reg;
	rfi_bank_state_t state_next;

	always_comb
	begin
		state_next = state_reg;
		if (wr_en)
			state_next.bits = rfi_setclr(state_reg.bits, wr_data);
		// an event in the clearing cycle is kept
		state_next.bits = state_next.bits | (hw_set & FLAG_MASK);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			state_reg <= '{bits: RESET_VAL};
		else
			state_reg <= state_next;
	end

	assign value = state_reg.bits;

endmodule

/* rfi_irq_ctrl.sv */
/*
 * Interrupt controller of a contactless reader frontend: two event flag
 * banks, two enable banks, status indication, interrupt request pin and
 * a FIFO threshold register, reached over Avalon-MM with waitrequest.
 * Assumes all event inputs are synchronous to clk_sys and reset_n is
 * driven from the power-down reset pin.
 */
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps

// Overview of operation
// - two 8-bit flag banks; each flag holds until software clears it
// - two 8-bit enable registers, one per flag bank, per-source enables
// - flag and enable register writes: bit 7 selects set or clear of marked bits 0..6
// - any reported event sets the interrupt bit in general status one
// - interrupt pin asserts for reported events only when pin signalling enabled
// - interrupt request pin is a dedicated output to the host
// - each countdown underflow sets its flag in the second bank
// - transmit-done set on change from payload to end-of-frame pattern
// - receive-done set when the receiver detects end of incoming data
// - disabled sources never cause an interrupt indication
// - any-source flag set whenever another enabled source flag is set
// - command-done set when the command returns to idle
// - receive-error flag set while any receive error bit is set
// - FIFO high and low alerts set when fill reaches threshold levels
module rfi_irq_ctrl
	import rfi_pkg::*;
#(
	parameter int FIFO_DEPTH = 512,
	parameter int FILL_W     = 10,
	parameter int THR_W      = 9
)
(
	input  wire logic                clk_sys,           // system clock, 25 MHz
	input  wire logic                reset_n,           // power-down reset, active low
	input  wire logic [ADDR_W-1:0]   avs_address,       // byte address
	input  wire logic                avs_read,          // read request
	input  wire logic                avs_write,         // write request
	input  wire logic [BUS_W-1:0]    avs_writedata,     // write data
	input  wire logic [3:0]          avs_byteenable,    // byte lanes
	output logic      [BUS_W-1:0]    avs_readdata,      // read data
	output logic                     avs_waitrequest,   // stall
	input  wire logic [N_TIMERS-1:0] timer_underflow,   // countdown underflow pulses
	input  wire logic                tx_sending_data,   // transmitter sending payload
	input  wire logic                tx_sending_eof,    // transmitter sending end pattern
	input  wire logic                rx_data_end,       // receiver end-of-data pulse
	input  wire logic                cmd_is_idle,       // command register holds idle
	input  wire logic [REG_W-1:0]    rx_error_bits,     // receive error register
	input  wire logic [FILL_W-1:0]   fifo_fill,         // FIFO fill count
	output logic [THR_W-1:0]         fifo_threshold,    // water level setting
	output logic                     irq_pin            // interrupt request pin
);

	typedef struct packed {
		logic               ack;
		logic [BUS_W-1:0]   rdata;
		logic               irq_pin;
		logic               status_irq;
		logic               pin_en;
		logic [THR_W-1:0]   thresh;
		logic               tx_data_prev;
		logic               idle_prev;
		logic               hi_prev;
		logic               lo_prev;
	} rfi_ctrl_state_t;

	rfi_ctrl_state_t state_reg;
	rfi_ctrl_state_t state_next;

	logic [REG_W-1:0] flags_first;
	logic [REG_W-1:0] flags_second;
	logic [REG_W-1:0] enable_first;
	logic [REG_W-1:0] enable_second;
	logic [REG_W-1:0] set_first;
	logic [REG_W-1:0] set_second;
	logic             wr_acc;
	logic             wr_flags_first;
	logic             wr_flags_second;
	logic             wr_enable_first;
	logic             wr_enable_second;
	logic             hi_now;
	logic             lo_now;
	logic             src_pending;
	logic             pending;
	logic [FILL_W-1:0] hi_level;

	// write takes effect on the edge where waitrequest is low
	assign wr_acc           = avs_write & state_reg.ack & avs_byteenable[0];
	assign wr_flags_first   = wr_acc && (avs_address == ADDR_FLAGS_FIRST);
	assign wr_flags_second  = wr_acc && (avs_address == ADDR_FLAGS_SECOND);
	assign wr_enable_first  = wr_acc && (avs_address == ADDR_ENABLE_FIRST);
	assign wr_enable_second = wr_acc && (avs_address == ADDR_ENABLE_SECOND);

	// high level counts down from the top of the FIFO by the same value
	assign hi_level = FILL_W'(FIFO_DEPTH) - FILL_W'(state_reg.thresh);
	assign hi_now   = fifo_fill >= hi_level;
	assign lo_now   = fifo_fill <= FILL_W'(state_reg.thresh);

	// the any-source flag looks only at the other sources
	assign src_pending = |(flags_first & enable_first & F1_SRC_MASK)
		| |(flags_second & enable_second & F2_SRC_MASK);
	assign pending = src_pending
		| (flags_second[F2_ANY] & enable_second[F2_ANY]);

	always_comb
	begin
		set_first                = '0;
		set_first[F1_RX_ERR]     = |rx_error_bits;
		set_first[F1_FIFO_LO]    = lo_now & ~state_reg.lo_prev;
		set_first[F1_FIFO_HI]    = hi_now & ~state_reg.hi_prev;
		set_first[F1_CMD_DONE]   = cmd_is_idle & ~state_reg.idle_prev;
		set_first[F1_RX_DONE]    = rx_data_end;
		set_first[F1_TX_DONE]    = state_reg.tx_data_prev & tx_sending_eof;
		set_second               = '0;
		set_second[F2_TIMER0 +: N_TIMERS] = timer_underflow;
		set_second[F2_ANY]       = src_pending;
	end

	rfi_flag_bank #(.RESET_VAL(FLAGS_RST)) u_flags_first (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.wr_en   (wr_flags_first),
		.wr_data (avs_writedata[REG_W-1:0]),
		.hw_set  (set_first),
		.value   (flags_first)
	);

	rfi_flag_bank #(.RESET_VAL(FLAGS_RST)) u_flags_second (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.wr_en   (wr_flags_second),
		.wr_data (avs_writedata[REG_W-1:0]),
		.hw_set  (set_second),
		.value   (flags_second)
	);

	rfi_flag_bank #(.RESET_VAL(ENABLE_RST)) u_enable_first (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.wr_en   (wr_enable_first),
		.wr_data (avs_writedata[REG_W-1:0]),
		.hw_set  ('0),
		.value   (enable_first)
	);

	rfi_flag_bank #(.RESET_VAL(ENABLE_RST)) u_enable_second (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.wr_en   (wr_enable_second),
		.wr_data (avs_writedata[REG_W-1:0]),
		.hw_set  ('0),
		.value   (enable_second)
	);

	always_comb
	begin
		state_next              = state_reg;
		state_next.tx_data_prev = tx_sending_data;
		state_next.idle_prev    = cmd_is_idle;
		state_next.hi_prev      = hi_now;
		state_next.lo_prev      = lo_now;
		state_next.status_irq   = pending;
		state_next.irq_pin      = pending & state_reg.pin_en;
		// one wait cycle; read data are captured then and stand at the answer
		if ((avs_read | avs_write) & ~state_reg.ack)
		begin
			state_next.ack   = 1'b1;
			state_next.rdata = '0;
			unique case (avs_address)
				ADDR_FLAGS_FIRST:   state_next.rdata[REG_W-1:0] = flags_first;
				ADDR_FLAGS_SECOND:  state_next.rdata[REG_W-1:0] = flags_second;
				ADDR_ENABLE_FIRST:  state_next.rdata[REG_W-1:0] = enable_first;
				ADDR_ENABLE_SECOND: state_next.rdata[REG_W-1:0] = enable_second;
				ADDR_STATUS_ONE:    state_next.rdata[STAT_IRQ_BIT] = state_reg.status_irq;
				ADDR_PIN_CONFIG:    state_next.rdata[CFG_PIN_EN_BIT] = state_reg.pin_en;
				ADDR_FIFO_THRESH:   state_next.rdata[THR_W-1:0] = state_reg.thresh;
				default:            state_next.rdata = '0;
			endcase
		end
		else
			state_next.ack = 1'b0;
		if (wr_acc && avs_address == ADDR_PIN_CONFIG)
			state_next.pin_en = avs_writedata[CFG_PIN_EN_BIT];
		if (wr_acc && avs_address == ADDR_FIFO_THRESH)
			state_next.thresh = avs_writedata[THR_W-1:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			state_reg <= '{ack: 1'b0, rdata: '0, irq_pin: 1'b0, status_irq: 1'b0,
				pin_en: PIN_EN_RST, thresh: THR_W'(THRESH_RST), tx_data_prev: 1'b0,
				idle_prev: 1'b0, hi_prev: 1'b0, lo_prev: 1'b0};
		else
			state_reg <= state_next;
	end

	assign avs_readdata    = state_reg.rdata;
	assign avs_waitrequest = ~state_reg.ack;
	assign irq_pin         = state_reg.irq_pin;
	assign fifo_threshold  = state_reg.thresh;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	property p_bit7_zero;
		flags_first[SETCLR_BIT] == 1'b0 && flags_second[SETCLR_BIT] == 1'b0;
	endproperty
	a_bit7_zero: assert property (p_bit7_zero) else $error("bit 7 of a flag bank is set");

	property p_timer_set;
		timer_underflow[0] |=> flags_second[F2_TIMER0];
	endproperty
	a_timer_set: assert property (p_timer_set) else $error("timer flag missed");

	property p_tx_done;
		tx_sending_data ##1 tx_sending_eof |=> flags_first[F1_TX_DONE];
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("transmit-done flag missed");

	property p_rx_done;
		rx_data_end |=> flags_first[F1_RX_DONE];
	endproperty
	a_rx_done: assert property (p_rx_done) else $error("receive-done flag missed");

	property p_err_set;
		(rx_error_bits != '0) |=> flags_first[F1_RX_ERR];
	endproperty
	a_err_set: assert property (p_err_set) else $error("receive-error flag missed");

	property p_cmd_done;
		!cmd_is_idle ##1 cmd_is_idle |=> flags_first[F1_CMD_DONE];
	endproperty
	a_cmd_done: assert property (p_cmd_done) else $error("command-done flag missed");

	property p_pin_follows;
		##1 irq_pin == ($past(|(flags_first & enable_first)
			| |(flags_second & enable_second)) && $past(state_reg.pin_en));
	endproperty
	a_pin_follows: assert property (p_pin_follows) else $error("irq pin mismatch");

	property p_status_gated;
		(flags_first & enable_first) == '0 && (flags_second & enable_second) == '0
			|=> !state_reg.status_irq;
	endproperty
	a_status_gated: assert property (p_status_gated) else $error("disabled source raised irq");

	property p_any_source;
		src_pending |=> flags_second[F2_ANY];
	endproperty
	a_any_source: assert property (p_any_source) else $error("any-source flag missed");

	property p_sw_set;
		wr_flags_first && avs_writedata[SETCLR_BIT] && avs_writedata[F1_RX_DONE]
			|=> flags_first[F1_RX_DONE];
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("software set failed");

	property p_sw_clear;
		wr_flags_first && !avs_writedata[SETCLR_BIT] && avs_writedata[F1_RX_DONE]
			&& !rx_data_end |=> !flags_first[F1_RX_DONE];
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("software clear failed");

	property p_bus_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

	// alerts fire on crossing a level; a fill that stays beyond it raises nothing more
	// the levels are taken from the threshold output so a rewrite is followed at once
	property p_lo_alert;
		$rose(fifo_fill <= FILL_W'(fifo_threshold)) |=> flags_first[F1_FIFO_LO];
	endproperty
	a_lo_alert: assert property (p_lo_alert) else $error("low alert flag missed");

	property p_hi_alert;
		$rose(fifo_fill >= FILL_W'(FIFO_DEPTH) - FILL_W'(fifo_threshold))
			|=> flags_first[F1_FIFO_HI];
	endproperty
	a_hi_alert: assert property (p_hi_alert) else $error("high alert flag missed");

	property p_enable_set;
		wr_enable_first && avs_writedata[SETCLR_BIT]
			|=> (enable_first & $past(avs_writedata[REG_W-1:0]) & FLAG_MASK)
			== ($past(avs_writedata[REG_W-1:0]) & FLAG_MASK);
	endproperty
	a_enable_set: assert property (p_enable_set) else $error("enable set failed");

	property p_enable_clear;
		wr_enable_second && !avs_writedata[SETCLR_BIT]
			|=> (enable_second & $past(avs_writedata[REG_W-1:0]) & FLAG_MASK) == '0;
	endproperty
	a_enable_clear: assert property (p_enable_clear) else $error("enable clear failed");

	property p_pin_gated;
		!state_reg.pin_en |=> !irq_pin;
	endproperty
	a_pin_gated: assert property (p_pin_gated) else $error("irq pin without pin enable");

	c_irq_pin:  cover property (!irq_pin ##1 irq_pin);
	c_tx_done:  cover property (tx_sending_data ##1 tx_sending_eof);
	c_sw_clear: cover property (wr_flags_second && !avs_writedata[SETCLR_BIT]);
	c_hi_alert: cover property (set_first[F1_FIFO_HI]);
	c_lo_alert: cover property (set_first[F1_FIFO_LO]);

endmodule

/* rfi_host_model.sv */
/*
 * Host microcontroller model: counts interrupt requests seen on the
 * request pin, the way an edge-triggered host interrupt input would.
 * Assumes irq_pin is a registered level synchronous to clk_sys.
 */
`timescale 1ns/1ps
module rfi_host_model
(
	input  wire logic       clk_sys,    // system clock
	input  wire logic       reset_n,    // synchronous reset, active low
	input  wire logic       irq_pin,    // interrupt request from the device
	output logic      [7:0] irq_count   // requests serviced so far
);
	logic irq_last;

	// edge counting: a level that never drops would be serviced only once
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			irq_last  <= 1'b0;
			irq_count <= 8'h00;
		end
		else
		begin
			irq_last <= irq_pin;
			if (irq_pin && !irq_last)
				irq_count <= irq_count + 8'h01;
		end
	end
endmodule

/* testbench.sv */
/*
 * Self-checking bench for the interrupt controller: register set/clear,
 * event sources, enable gating and pin signalling over Avalon-MM.
 * Assumes the package offsets and the one-wait-state bus answer.
 */
`timescale 1ns/1ps
module testbench;
	import rfi_pkg::*;
	logic              clk_sys, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [ADDR_W-1:0] avs_address;
	logic [BUS_W-1:0]  avs_writedata, avs_readdata, q;
	logic [3:0]        avs_byteenable, timer_underflow;
	logic              tx_sending_data, tx_sending_eof, rx_data_end, cmd_is_idle, irq_pin;
	logic [7:0]        rx_error_bits, irq_count, e1, e2, wd;
	logic [7:0]        exp_r[4];
	logic [9:0]        fifo_fill;
	logic [8:0]        fifo_threshold;
	logic [ADDR_W-1:0] ra[4];
	int                error_cnt, checks_done, r;

	rfi_irq_ctrl u_rfi_irq_ctrl (.clk_sys(clk_sys), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.timer_underflow(timer_underflow), .tx_sending_data(tx_sending_data),
		.tx_sending_eof(tx_sending_eof), .rx_data_end(rx_data_end),
		.cmd_is_idle(cmd_is_idle), .rx_error_bits(rx_error_bits),
		.fifo_fill(fifo_fill), .fifo_threshold(fifo_threshold), .irq_pin(irq_pin));
	rfi_host_model u_rfi_host_model (.clk_sys(clk_sys), .reset_n(reset_n),
		.irq_pin(irq_pin), .irq_count(irq_count));

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one request, held until waitrequest is sampled low; a missing answer is left to the watchdog
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		avs_write     <= w;
		avs_read      <= !w;
		avs_address   <= a;
		avs_writedata <= {24'h000000, d};
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(q, {24'h000000, exp});
	endtask

	function automatic logic [7:0] setclr(input logic [7:0] o, input logic [7:0] w);
		if (w[7])
			return (o | w) & 8'h7F;
		return o & ~w & 8'h7F;
	endfunction

	// drive one event source; e1/e2 give the flags it should leave behind
	task automatic fire(input int k);
		e1 = 8'h00;
		e2 = 8'h40;
		if (k < 4)
			e2 = 8'h40 | (8'h01 << k);
		case (k)
			0, 1, 2, 3: timer_underflow <= 4'h1 << k;
			4: rx_data_end <= 1'b1;
			5: tx_sending_data <= 1'b1;
			6: cmd_is_idle <= 1'b1;
			7: rx_error_bits <= 8'h01 << ($urandom % 8);
			8: fifo_fill <= 10'(THRESH_RST);
			default: fifo_fill <= 10'(512 - THRESH_RST);
		endcase
		e1 = (k == 4) ? 8'h10 : (k == 5) ? 8'h20 : (k == 6) ? 8'h08 :
			(k == 7) ? 8'h01 : (k == 8) ? 8'h02 : (k == 9) ? 8'h04 : 8'h00;
		@(posedge clk_sys);
		timer_underflow <= 4'h0;
		rx_data_end     <= 1'b0;
		tx_sending_eof  <= tx_sending_data;
		tx_sending_data <= 1'b0;
		@(posedge clk_sys);
		tx_sending_eof <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	// any-source is cleared last, since it re-sets while others are pending
	task automatic clear_all;
		rx_error_bits <= 8'h00;
		cmd_is_idle   <= 1'b0;
		fifo_fill     <= 10'h064;
		bus(1'b1, ADDR_FLAGS_FIRST, 8'h7F);
		bus(1'b1, ADDR_FLAGS_SECOND, 8'h3F);
		bus(1'b1, ADDR_FLAGS_SECOND, 8'h40);
		repeat (3) @(posedge clk_sys);
	endtask

	initial
	begin
		repeat (5000) @(posedge clk_sys);
		error_cnt++;
		report_and_stop();
	end

	initial
	begin
		{reset_n, avs_read, avs_write, tx_sending_data, tx_sending_eof} = 5'h00;
		{rx_data_end, cmd_is_idle, timer_underflow, rx_error_bits} = 14'h0000;
		avs_address    = 5'h00;
		avs_writedata  = 32'h00000000;
		avs_byteenable = 4'hF;
		fifo_fill      = 10'h064;
		error_cnt      = 0;
		checks_done    = 0;
		ra = '{ADDR_FLAGS_FIRST, ADDR_FLAGS_SECOND, ADDR_ENABLE_FIRST, ADDR_ENABLE_SECOND};
		void'($urandom(32'h93B47C42));
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 4; i++)
			rd(ra[i], 8'h00);
		rd(ADDR_STATUS_ONE, 8'h00);
		rd(ADDR_PIN_CONFIG, 8'h00);
		rd(5'h1C, 8'h00);
		check(fifo_threshold, THRESH_RST);
		check(irq_pin, 1'b0);
		$display("test reset values done");

		// flags first with enables at zero, then enables with flags at zero
		exp_r = '{8'h00, 8'h00, 8'h00, 8'h00};
		for (int ph = 0; ph < 2; ph++)
		begin
			for (int i = 0; i < 12; i++)
			begin
				r = ph * 2 + i % 2;
				wd = (i < 2) ? 8'hFF : (i < 4) ? 8'h80 : 8'($urandom);
				bus(1'b1, ra[r], wd);
				exp_r[r] = setclr(exp_r[r], wd);
				rd(ra[r], exp_r[r]);
			end
			if (ph == 0)
				clear_all();
		end
		check(irq_pin, 1'b0);
		avs_byteenable <= 4'h0;
		bus(1'b1, ADDR_FLAGS_FIRST, 8'hFF);
		avs_byteenable <= 4'hF;
		rd(ADDR_FLAGS_FIRST, 8'h00);
		$display("test set and clear writes done");

		bus(1'b1, ADDR_ENABLE_FIRST, 8'hFF);
		bus(1'b1, ADDR_ENABLE_SECOND, 8'hFF);
		bus(1'b1, ADDR_PIN_CONFIG, 8'h01);
		for (int k = 0; k < 10; k++)
		begin
			fire(k);
			check(irq_pin, 1'b1);
			rd(ADDR_STATUS_ONE, 8'h01);
			rd(ADDR_FLAGS_FIRST, e1);
			rd(ADDR_FLAGS_SECOND, e2);
			clear_all();
			check(irq_pin, 1'b0);
		end
		$display("test event sources done");

		bus(1'b1, ADDR_ENABLE_FIRST, 8'h7F);
		fire(4);
		check(irq_pin, 1'b0);
		rd(ADDR_STATUS_ONE, 8'h00);
		rd(ADDR_FLAGS_FIRST, 8'h10);
		rd(ADDR_FLAGS_SECOND, 8'h00);
		clear_all();
		bus(1'b1, ADDR_ENABLE_FIRST, 8'hFF);
		bus(1'b1, ADDR_PIN_CONFIG, 8'h00);
		fire(4);
		check(irq_pin, 1'b0);
		rd(ADDR_STATUS_ONE, 8'h01);
		clear_all();
		check(irq_count, 8'h0A);
		$display("test gating done");

		// a new threshold moves the low level: just above it stays quiet, reaching it alerts
		bus(1'b1, ADDR_FIFO_THRESH, 8'h20);
		rd(ADDR_FIFO_THRESH, 8'h20);
		check(fifo_threshold, 9'h020);
		fifo_fill <= 10'h021;
		repeat (2) @(posedge clk_sys);
		rd(ADDR_FLAGS_FIRST, 8'h00);
		fifo_fill <= 10'h020;
		repeat (2) @(posedge clk_sys);
		rd(ADDR_FLAGS_FIRST, 8'h02);
		clear_all();
		$display("test threshold done");
		report_and_stop();
	end
endmodule
